// ---- logic/iepb_params.svh ----
// constants of the interrupt enable and priority bank
`ifndef IEPB_PARAMS_SVH
`define IEPB_PARAMS_SVH

// ***************
// register byte offsets
// ***************
`define IEPB_ADDR_W      8
`define IEPB_OFF_EN4     8'h00
`define IEPB_OFF_PRIO0   8'h04
`define IEPB_OFF_PRIO1   8'h08
`define IEPB_OFF_PRIO2   8'h0c
`define IEPB_OFF_PRIO3   8'h10
`define IEPB_OFF_PRIO4   8'h14
`define IEPB_OFF_STATUS  8'h18
`define IEPB_OFF_CLEAR   8'h1c
`define IEPB_OFF_IRQEN   8'h20
`define IEPB_OFF_ARB     8'h24

// ***************
// writable masks and reset values
// ***************
`define IEPB_EN4_MASK    16'h010e
`define IEPB_EN4_RST     16'h0000
`define IEPB_PRIO0_MASK  16'h7777
`define IEPB_PRIO1_MASK  16'h7770
`define IEPB_PRIO2_MASK  16'h7777
`define IEPB_PRIO3_MASK  16'h0077
`define IEPB_PRIO4_MASK  16'h7777
`define IEPB_PRIO0_RST   16'h4444
`define IEPB_PRIO1_RST   16'h4440
`define IEPB_PRIO2_RST   16'h4444
`define IEPB_PRIO3_RST   16'h0044
`define IEPB_PRIO4_RST   16'h4444

// ***************
// field positions
// ***************
`define IEPB_LOW_VOLTAGE_IRQ_EN_BIT   8
`define IEPB_CHECKSUM_GEN_IRQ_EN_BIT  3
`define IEPB_SERIAL2_ERROR_IRQ_EN_BIT 2
`define IEPB_SERIAL1_ERROR_IRQ_EN_BIT 1
`define IEPB_EVT_FWD     0
`define IEPB_EVT_BLK     1

// ***************
// sizes, levels and bus answers
// ***************
`define IEPB_NUM_PRIO_SRC 17
`define IEPB_NUM_EN_SRC   4
`define IEPB_NUM_SRC      21
`define IEPB_NUM_EVT      2
`define IEPB_FIXED_LEVEL  3'h4
`define IEPB_RESP_OKAY    2'h0
`define IEPB_RESP_SLVERR  2'h2

`endif

// ---- logic/iepb_pkg.sv ----
// types of the interrupt enable and priority bank
`include "iepb_params.svh"

package iepb_pkg;

  typedef enum logic [3:0] {
    IEPB_REG_EN4    = 4'h0,
    IEPB_REG_PRIO   = 4'h1,
    IEPB_REG_STATUS = 4'h2,
    IEPB_REG_CLEAR  = 4'h3,
    IEPB_REG_IRQEN  = 4'h4,
    IEPB_REG_ARB    = 4'h5,
    IEPB_REG_NONE   = 4'h6
  } iepb_reg_t;

  typedef struct packed {
    logic [15:0]                    en4;
    logic [4:0][15:0]               prio;
    logic [`IEPB_NUM_EVT-1:0]       status;
    logic [`IEPB_NUM_EVT-1:0]       irq_en;
    logic                           irq;
    logic                           aw_held;
    logic [`IEPB_ADDR_W-1:0]        aw_addr;
    logic                           w_held;
    logic [15:0]                    wdata;
    logic [1:0]                     wstrb;
    logic                           awready;
    logic                           wready;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           arready;
    logic                           rvalid;
    logic [31:0]                    rdata;
    logic [1:0]                     rresp;
    logic                           core_req;
    logic [2:0]                     core_level;
    logic [4:0]                     core_src;
  } iepb_state_t;

endpackage

// ---- logic/iepb_top.sv ----
// interrupt enable and priority bank with axi4-lite register slave
`timescale 1ns/10ps

module iepb_top (
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  input  wire logic                          ce_in,
  input  wire logic [`IEPB_NUM_PRIO_SRC-1:0] prio_src_req_in,
  input  wire logic [`IEPB_NUM_EN_SRC-1:0]   en_src_req_in,
  input  wire logic [31:0]                   s_axi_awaddr_in,
  input  wire logic                          s_axi_awvalid_in,
  output logic                               s_axi_awready_out,
  input  wire logic [31:0]                   s_axi_wdata_in,
  input  wire logic [3:0]                    s_axi_wstrb_in,
  input  wire logic                          s_axi_wvalid_in,
  output logic                               s_axi_wready_out,
  output logic [1:0]                         s_axi_bresp_out,
  output logic                               s_axi_bvalid_out,
  input  wire logic                          s_axi_bready_in,
  input  wire logic [31:0]                   s_axi_araddr_in,
  input  wire logic                          s_axi_arvalid_in,
  output logic                               s_axi_arready_out,
  output logic [31:0]                        s_axi_rdata_out,
  output logic [1:0]                         s_axi_rresp_out,
  output logic                               s_axi_rvalid_out,
  input  wire logic                          s_axi_rready_in,
  output logic                               core_req_out,
  output logic [2:0]                         core_level_out,
  output logic [4:0]                         core_src_out,
  output logic                               irq_out
);

  // ***************
  // constant tables
  // ***************
  localparam logic [4:0][15:0] PRIO_MASK = {
    `IEPB_PRIO4_MASK, `IEPB_PRIO3_MASK, `IEPB_PRIO2_MASK,
    `IEPB_PRIO1_MASK, `IEPB_PRIO0_MASK};
  localparam logic [4:0][15:0] PRIO_RST = {
    `IEPB_PRIO4_RST, `IEPB_PRIO3_RST, `IEPB_PRIO2_RST,
    `IEPB_PRIO1_RST, `IEPB_PRIO0_RST};

  // bank and field lsb of each priority source, index 16 first
  localparam logic [16:0][2:0] SRC_BANK = {
    3'h4, 3'h4, 3'h4, 3'h4,
    3'h3, 3'h3,
    3'h2, 3'h2, 3'h2, 3'h2,
    3'h1, 3'h1, 3'h1,
    3'h0, 3'h0, 3'h0, 3'h0};
  localparam logic [16:0][3:0] SRC_LSB = {
    4'h0, 4'h4, 4'h8, 4'hc,
    4'h0, 4'h4,
    4'h0, 4'h4, 4'h8, 4'hc,
    4'h4, 4'h8, 4'hc,
    4'h0, 4'h4, 4'h8, 4'hc};

  // enable bank bit of each enable-gated source, index 3 first
  localparam logic [3:0][3:0] EN_BIT = {
    4'(`IEPB_LOW_VOLTAGE_IRQ_EN_BIT),
    4'(`IEPB_CHECKSUM_GEN_IRQ_EN_BIT),
    4'(`IEPB_SERIAL2_ERROR_IRQ_EN_BIT),
    4'(`IEPB_SERIAL1_ERROR_IRQ_EN_BIT)};

  localparam iepb_pkg::iepb_state_t STATE_RST = '{
    en4:        `IEPB_EN4_RST,
    prio:       PRIO_RST,
    status:     '0,
    irq_en:     '0,
    irq:        1'b0,
    aw_held:    1'b0,
    aw_addr:    '0,
    w_held:     1'b0,
    wdata:      16'h0000,
    wstrb:      2'h0,
    awready:    1'b0,
    wready:     1'b0,
    bvalid:     1'b0,
    bresp:      `IEPB_RESP_OKAY,
    arready:    1'b0,
    rvalid:     1'b0,
    rdata:      32'h0000_0000,
    rresp:      `IEPB_RESP_OKAY,
    core_req:   1'b0,
    core_level: 3'h0,
    core_src:   5'h00};

  iepb_pkg::iepb_state_t s_reg;
  iepb_pkg::iepb_state_t s_next;

  logic [`IEPB_NUM_SRC-1:0][2:0]     eff_lvl;
  logic [`IEPB_NUM_PRIO_SRC-1:0][2:0] raw_lvl;
  logic [`IEPB_NUM_SRC-1:0]          blocked;

  // ***************
  // address decode
  // ***************
  function automatic iepb_pkg::iepb_reg_t decode(
    input logic [`IEPB_ADDR_W-1:0] addr,
    output logic [2:0]             bank
  );
    iepb_pkg::iepb_reg_t sel;
    sel  = iepb_pkg::IEPB_REG_NONE;
    bank = 3'h0;
    case (addr)
      `IEPB_OFF_EN4:    sel = iepb_pkg::IEPB_REG_EN4;
      `IEPB_OFF_STATUS: sel = iepb_pkg::IEPB_REG_STATUS;
      `IEPB_OFF_CLEAR:  sel = iepb_pkg::IEPB_REG_CLEAR;
      `IEPB_OFF_IRQEN:  sel = iepb_pkg::IEPB_REG_IRQEN;
      `IEPB_OFF_ARB:    sel = iepb_pkg::IEPB_REG_ARB;
      default: begin
        if (addr >= `IEPB_OFF_PRIO0 && addr <= `IEPB_OFF_PRIO4 &&
            addr[1:0] == 2'h0) begin
          sel  = iepb_pkg::IEPB_REG_PRIO;
          bank = 3'((addr - `IEPB_OFF_PRIO0) >> 2);
        end
      end
    endcase
    return sel;
  endfunction

  // ***************
  // per-source effective level
  // ***************
  genvar gi;
  generate
    for (gi = 0; gi < `IEPB_NUM_PRIO_SRC; gi++) begin : g_prio
      assign raw_lvl[gi] = s_reg.prio[SRC_BANK[gi]][SRC_LSB[gi] +: 3];
      // level zero never reaches the arbiter
      assign eff_lvl[gi] = prio_src_req_in[gi] ? raw_lvl[gi] : 3'h0;
      assign blocked[gi] = prio_src_req_in[gi] && raw_lvl[gi] == 3'h0;
    end
    for (gi = 0; gi < `IEPB_NUM_EN_SRC; gi++) begin : g_en
      assign eff_lvl[`IEPB_NUM_PRIO_SRC + gi] =
        (en_src_req_in[gi] && s_reg.en4[EN_BIT[gi]]) ?
        `IEPB_FIXED_LEVEL : 3'h0;
      assign blocked[`IEPB_NUM_PRIO_SRC + gi] =
        en_src_req_in[gi] && !s_reg.en4[EN_BIT[gi]];
    end
  endgenerate

  // ***************
  // next-state logic
  // ***************
  always_comb begin
    iepb_pkg::iepb_reg_t         wsel;
    iepb_pkg::iepb_reg_t         rsel;
    logic [2:0]                  wbank;
    logic [2:0]                  rbank;
    logic [15:0]                 wmask;
    logic [15:0]                 rval;
    logic [`IEPB_NUM_EVT-1:0]    clr;
    logic [`IEPB_NUM_EVT-1:0]    set;
    logic [2:0]                  best_lvl;
    logic [4:0]                  best_id;
    wsel     = iepb_pkg::IEPB_REG_NONE;
    rsel     = iepb_pkg::IEPB_REG_NONE;
    wbank    = 3'h0;
    rbank    = 3'h0;
    wmask    = 16'h0000;
    rval     = 16'h0000;
    clr      = '0;
    set      = '0;
    best_lvl = 3'h0;
    best_id  = 5'h00;
    s_next   = s_reg;

    // write address and data are taken independently
    if (s_axi_awvalid_in && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr_in[`IEPB_ADDR_W-1:0];
    end
    if (s_axi_wvalid_in && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata  = s_axi_wdata_in[15:0];
      s_next.wstrb  = s_axi_wstrb_in[1:0];
    end
    if (s_reg.bvalid && s_axi_bready_in) begin
      s_next.bvalid = 1'b0;
    end

    // both halves present: perform the write and answer
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = `IEPB_RESP_OKAY;
      wmask = {{8{s_reg.wstrb[1]}}, {8{s_reg.wstrb[0]}}};
      wsel  = decode(s_reg.aw_addr, wbank);
      case (wsel)
        iepb_pkg::IEPB_REG_EN4: begin
          wmask = wmask & `IEPB_EN4_MASK;
          s_next.en4 = (s_reg.en4 & ~wmask) | (s_reg.wdata & wmask);
        end
        iepb_pkg::IEPB_REG_PRIO: begin
          wmask = wmask & PRIO_MASK[wbank];
          s_next.prio[wbank] = (s_reg.prio[wbank] & ~wmask) |
                               (s_reg.wdata & wmask);
        end
        iepb_pkg::IEPB_REG_CLEAR: begin
          clr = s_reg.wdata[`IEPB_NUM_EVT-1:0] &
                {`IEPB_NUM_EVT{s_reg.wstrb[0]}};
        end
        iepb_pkg::IEPB_REG_IRQEN: begin
          if (s_reg.wstrb[0]) begin
            s_next.irq_en = s_reg.wdata[`IEPB_NUM_EVT-1:0];
          end
        end
        iepb_pkg::IEPB_REG_STATUS,
        iepb_pkg::IEPB_REG_ARB: begin
          // read-only, write ignored
        end
        default: begin
          s_next.bresp = `IEPB_RESP_SLVERR;
        end
      endcase
    end

    // read channel
    if (s_reg.rvalid && s_axi_rready_in) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_reg.arready) begin
      rsel = decode(s_axi_araddr_in[`IEPB_ADDR_W-1:0], rbank);
      s_next.rresp = `IEPB_RESP_OKAY;
      case (rsel)
        iepb_pkg::IEPB_REG_EN4:    rval = s_reg.en4 & `IEPB_EN4_MASK;
        iepb_pkg::IEPB_REG_PRIO:   rval = s_reg.prio[rbank] &
                                          PRIO_MASK[rbank];
        iepb_pkg::IEPB_REG_STATUS: rval = 16'(s_reg.status);
        iepb_pkg::IEPB_REG_CLEAR:  rval = 16'h0000;
        iepb_pkg::IEPB_REG_IRQEN:  rval = 16'(s_reg.irq_en);
        iepb_pkg::IEPB_REG_ARB:    rval = {7'h00, s_reg.core_req,
                                           s_reg.core_level, s_reg.core_src};
        default: begin
          rval = 16'h0000;
          s_next.rresp = `IEPB_RESP_SLVERR;
        end
      endcase
      s_next.rdata  = {16'h0000, rval};
      s_next.rvalid = 1'b1;
    end

    // highest level wins, lower source index breaks a tie
    for (int i = 0; i < `IEPB_NUM_SRC; i++) begin
      if (eff_lvl[i] > best_lvl) begin
        best_lvl = eff_lvl[i];
        best_id  = 5'(i);
      end
    end
    s_next.core_req   = best_lvl != 3'h0;
    s_next.core_level = best_lvl;
    s_next.core_src   = best_id;

    // sticky events, a set in the clearing cycle wins
    set[`IEPB_EVT_FWD] = s_next.core_req && !s_reg.core_req;
    set[`IEPB_EVT_BLK] = |blocked;
    s_next.status = (s_reg.status & ~clr) | set;
    s_next.irq    = |(s_next.status & s_next.irq_en);

    // ready only while the channel holds nothing and no answer waits
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready  = !s_next.w_held && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  // ***************
  // state register
  // ***************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= STATE_RST;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  // ***************
  // outputs
  // ***************
  assign s_axi_awready_out = s_reg.awready;
  assign s_axi_wready_out  = s_reg.wready;
  assign s_axi_bresp_out   = s_reg.bresp;
  assign s_axi_bvalid_out  = s_reg.bvalid;
  assign s_axi_arready_out = s_reg.arready;
  assign s_axi_rdata_out   = s_reg.rdata;
  assign s_axi_rresp_out   = s_reg.rresp;
  assign s_axi_rvalid_out  = s_reg.rvalid;
  assign core_req_out      = s_reg.core_req;
  assign core_level_out    = s_reg.core_level;
  assign core_src_out      = s_reg.core_src;
  assign irq_out           = s_reg.irq;

endmodule

// ---- verif/iepb_props.sv ----
// port assertions of the enable and priority bank
`timescale 1ns/10ps

module iepb_props (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  input wire logic [16:0] prio_src_req_in,
  input wire logic [3:0]  en_src_req_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        core_req_out,
  input wire logic [2:0]  core_level_out,
  input wire logic [4:0]  core_src_out
);
  logic [20:0] src_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // requests as the bank saw them one edge ago
  always_ff @(posedge clk_in) begin
    src_q <= {en_src_req_in, prio_src_req_in};
  end
  sequence s_wr_take;
    ce_in && s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_wr_resp;
    ##2 s_axi_bvalid_out;
  endsequence
  a_write_answer: assert property (s_wr_take |-> s_wr_resp)
    else $error("write response missing");
  a_read_answer: assert property (
    ce_in && s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response missing");
  a_bresp_hold: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  a_rdata_upper: assert property (
    s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_level_zero: assert property (
    core_req_out == (core_level_out != 3'h0))
    else $error("request with level zero");
  a_idle_quiet: assert property (
    ce_in && prio_src_req_in == 17'h0 && en_src_req_in == 4'h0
    |=> !core_req_out)
    else $error("request without source");
  a_src_active: assert property (
    core_req_out |-> src_q[core_src_out])
    else $error("winner not requesting");
  a_fixed_level: assert property (
    core_req_out && core_src_out > 5'h10 |-> core_level_out == 3'h4)
    else $error("gated source level wrong");
endmodule

// ---- verif/iepb_src_model.sv ----
// peripheral request sources facing the enable and priority bank
`timescale 1ns/10ps

module iepb_src_model (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [20:0] want_in,
  input  wire logic [1:0]  lag_in,
  output logic      [16:0] prio_req_out,
  output logic      [3:0]  en_req_out
);
  logic [1:0] wait_reg;
  // a slow source changes its level only after lag_in idle edges
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_reg <= 2'h0;
      {en_req_out, prio_req_out} <= 21'h0;
    end else if ({en_req_out, prio_req_out} == want_in) begin
      wait_reg <= lag_in;
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end else begin
      {en_req_out, prio_req_out} <= want_in;
    end
  end
endmodule

// ---- verif/iepb_top_test.sv ----
// self-checking bench of the enable and priority bank
`timescale 1ns/10ps
`include "iepb_params.svh"

module iepb_top_test;
  logic        clk_in = 1'h0;
  logic        rstn_in = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, ce = 1'h1;
  logic        awready, wready, bvalid, arready, rvalid, creq, irq;
  logic [1:0]  bresp, rresp, lag = 2'h0;
  logic [20:0] want = 21'h0;
  logic [16:0] preq;
  logic [3:0]  ereq;
  logic [2:0]  clev;
  logic [4:0]  csrc;
  logic [33:0] exp_q[$];
  logic [15:0] pb[5], en_m;
  logic [15:0] msk[5] = '{16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h7777};
  int          miscompares = 0, checks = 0, i, k;
  int          bk[17] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 4};
  int          sh[17] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 0};
  int          eb[4] = '{1, 2, 3, 8};

  iepb_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
    .prio_src_req_in(preq), .en_src_req_in(ereq),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .core_req_out(creq),
    .core_level_out(clev), .core_src_out(csrc), .irq_out(irq));
  iepb_src_model src_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .want_in(want), .lag_in(lag), .prio_req_out(preq), .en_req_out(ereq));

  always #4 clk_in = ~clk_in;

  // ****************
  // checking
  // ****************
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge clk_in) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
  end
  task automatic summarize;
    if (exp_q.size() != 0) miscompares++;
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  // ****************
  // bus and source tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
                    input logic [1:0] r);
    int n;
    exp_q.push_back({r, 32'h0});
    awaddr <= {24'h0, a};
    wdata <= {16'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] v,
                    input logic [1:0] r);
    int n;
    exp_q.push_back({r, 16'h0, v});
    araddr <= {24'h0, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic wreg(input int b, input logic [15:0] v);
    wr(b == 5 ? 8'h00 : 8'(4 * b + 4), v, 2'h0);
    if (b == 5) en_m = v & 16'h010e;
    else pb[b] = v & msk[b];
  endtask
  task automatic chk_regs;
    for (k = 0; k < 5; k++) rd(8'(4 * k + 4), pb[k], 2'h0);
    rd(8'h00, en_m, 2'h0);
  endtask
  function automatic logic [8:0] win(input logic [20:0] q);
    logic [8:0] w;
    logic [2:0] l;
    w = 9'h0;
    for (int j = 0; j < 21; j++) begin
      l = j < 17 ? pb[bk[j]][sh[j] +: 3] :
          (en_m[eb[j - 17]] ? `IEPB_FIXED_LEVEL : 3'h0);
      if (q[j] && l > w[7:5]) w = {1'h1, l, 5'(j)};
    end
    return w;
  endfunction
  task automatic arb(input logic [20:0] q);
    int n;
    want <= q;
    for (n = 0; n < 20 && {ereq, preq} !== q; n++) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
    chk({25'h0, creq, clev, csrc}, {25'h0, win(q)});
    rd(8'h24, {7'h0, win(q)}, 2'h0);
  endtask

  initial begin
    i = $urandom(32'h600e);
    for (k = 0; k < 5; k++) pb[k] = msk[k] & 16'h4444;
    en_m = 16'h0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    chk_regs();
    arb(21'h1ffff);
    wreg(0, 16'h7010);
    arb(21'h00011);
    arb(21'h0000e);
    arb(21'h0000a);
    for (i = 0; i < 4; i++) begin
      wreg(5, 16'h1 << eb[i]);
      arb(21'h1 << (17 + i));
      wreg(5, 16'h0);
      arb(21'h1 << (17 + i));
    end
    arb(21'h0);
    wr(8'h1c, 16'h0003, 2'h0);
    wr(8'h20, 16'h0003, 2'h0);
    rd(8'h18, 16'h0000, 2'h0);
    arb(21'h0000a);
    rd(8'h18, 16'h0002, 2'h0);
    chk({33'h0, irq}, 34'h1);
    wr(8'h20, 16'h0001, 2'h0);
    chk({33'h0, irq}, 34'h0);
    arb(21'h00001);
    chk({33'h0, irq}, 34'h1);
    arb(21'h0);
    // clock enable low freezes the arbiter outputs
    ce <= 1'h0;
    want <= 21'h1;
    repeat (6) @(posedge clk_in);
    chk({33'h0, creq}, 34'h0);
    ce <= 1'h1;
    arb(21'h0);
    wr(8'h1c, 16'h0003, 2'h0);
    wr(8'h18, 16'hffff, 2'h0);
    rd(8'h18, 16'h0000, 2'h0);
    chk({33'h0, irq}, 34'h0);
    wr(8'h40, 16'hffff, 2'h2);
    rd(8'h40, 16'h0000, 2'h2);
    rd(8'h02, 16'h0000, 2'h2);
    for (i = 0; i < 6; i++) wreg(i, 16'hffff);
    chk_regs();
    for (i = 0; i < 40; i++) begin
      wreg(i % 6, 16'($urandom));
      lag <= 2'($urandom);
      arb(21'($urandom));
    end
    chk_regs();
    rstn_in <= 1'h0;
    for (k = 0; k < 5; k++) pb[k] = msk[k] & 16'h4444;
    en_m = 16'h0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    chk_regs();
    summarize();
  end
endmodule

bind iepb_top iepb_props props_u (.clk_in, .rstn_in, .ce_in,
  .prio_src_req_in, .en_src_req_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .core_req_out,
  .core_level_out, .core_src_out);
